// ---- lookup_table_config_and_permission_tb.sv ----
/*
  Self-checking bench for the table-set guard.
  Assumes pipe_model as requester and the bound port checker.
*/
module lookup_table_config_and_permission_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, allow, fault, done, mfault, bwe;
  logic [63:0] rdata;
  logic [1:0] bset;
  table_cfg_pkg::table_req_s op_req;
  table_cfg_pkg::reg_move_s mv;
  table_cfg_pkg::table_decode_s dec;
  int fail_count, comparisons, cyc;
  localparam logic [1:0] CF = table_cfg_pkg::SEL_CONFIG;
  localparam logic [1:0] PM = table_cfg_pkg::SEL_PERM;

  pipe_model u_pipe (.clk_i(clk_i), .op_o(op_req), .mv_o(mv));
  table_set_guard u_dut (.clk_i(clk_i), .rst_i(rst_i), .op_req_i(op_req),
    .move_i(mv), .op_allow_o(allow), .op_fault_o(fault),
    .move_done_o(done), .move_fault_o(mfault), .move_rdata_o(rdata),
    .base_we_o(bwe), .base_set_o(bset), .decode_o(dec));

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task automatic t_reset;
    u_pipe.mv(1'b0, PM, 2'h0, 1'b1, 64'h0);
    check(rdata, 64'h0);
    u_pipe.op(table_cfg_pkg::OP_READ, 2'h0, 1'b0);
    check(fault, 1'b1);
    $display("reset test done");
  endtask : t_reset
  task automatic t_perm_reg;
    u_pipe.mv(1'b1, PM, 2'h0, 1'b1, 64'hFFFFFFFFFFFFFFFF);
    u_pipe.mv(1'b0, PM, 2'h0, 1'b1, 64'h0);
    check(rdata, 64'h3333);
    u_pipe.mv(1'b1, PM, 2'h0, 1'b0, 64'h0);
    check(mfault, 1'b1);
    u_pipe.mv(1'b0, PM, 2'h0, 1'b1, 64'h0);
    check(rdata, 64'h3333);
    u_pipe.mv(1'b1, table_cfg_pkg::SEL_BASE, 2'h3, 1'b1, 64'h0);
    check(mfault, 1'b0);
    check(done, 1'b1);
    $display("perm register test done");
  endtask : t_perm_reg
  task automatic t_matrix;
    table_cfg_pkg::table_op_e o;
    logic exp;
    for (int c = 0; c < 4; c++) begin
      u_pipe.mv(1'b1, PM, 2'h0, 1'b1, 64'h3303 | (64'(c) << 4));
      for (int k = 1; k < 6; k++) begin
        o = table_cfg_pkg::table_op_e'(k);
        exp = (c >= 2) || (c == 1 && k == 1);
        u_pipe.op(o, 2'h1, 1'b0);
        check(allow, exp);
        u_pipe.op(o, 2'h1, 1'b1);
        check(allow, 1'b1);
      end
      u_pipe.mv(1'b0, CF, 2'h1, 1'b0, 64'h0);
      check(mfault, c == 0);
      u_pipe.mv(1'b1, table_cfg_pkg::SEL_BASE, 2'h1, 1'b0, 64'h0);
      check(mfault, c != 3);
    end
    $display("permission matrix test done");
  endtask : t_matrix
  task automatic t_decode;
    u_pipe.mv(1'b1, CF, 2'h2, 1'b1, 64'h14A);
    u_pipe.op(table_cfg_pkg::OP_READ, 2'h2, 1'b1);
    check(dec.is_signed, 1'b1);
    check(dec.element_size_field, 2'h1);
    check(dec.tables, 5'h4);
    check(dec.returned, 4'h4);
    check(dec.written, 4'h2);
    check(dec.cfg_valid, 1'b0);
    u_pipe.mv(1'b1, CF, 2'h2, 1'b1, 64'h200001D);
    u_pipe.op(table_cfg_pkg::OP_READ, 2'h2, 1'b1);
    check(dec.element_size_field, 2'h0);
    check(dec.tables, 5'h1);
    check(dec.returned, 4'h8);
    check(dec.written, 4'h1);
    check(dec.promotion_field_factor, 4'h4);
    check(dec.cfg_valid, 1'b1);
    u_pipe.mv(1'b1, CF, 2'h3, 1'b1, 64'h0000000001000311);
    u_pipe.op(table_cfg_pkg::OP_READ, 2'h3, 1'b1);
    check(dec.written, 4'h8);
    check(dec.promotion_field_factor, 4'h2);
    check(dec.cfg_valid, 1'b0);
    u_pipe.mv(1'b1, CF, 2'h3, 1'b1, 64'h0000000000000114);
    u_pipe.op(table_cfg_pkg::OP_READ, 2'h3, 1'b1);
    check(dec.tables, 5'h10);
    check(dec.returned, 4'h1);
    check(dec.cfg_valid, 1'b0);
    $display("decode test done");
  endtask : t_decode

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 2000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    #1 rst_i = 1'b0;
    t_reset();
    t_perm_reg();
    t_matrix();
    t_decode();
    tally_and_finish();
  end
endmodule : lookup_table_config_and_permission_tb

// ---- pipe_model.sv ----
/*
  Pipeline partner: issues table ops and register moves.
  Assumes the guard answers one cycle after each request.
*/
module pipe_model (
  input  wire logic                  clk_i,
  output table_cfg_pkg::table_req_s  op_o,
  output table_cfg_pkg::reg_move_s   mv_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    op_o = '0;
    mv_o = '0;
  end
  // Released fields show inverted junk, never a stale request
  task automatic op(input table_cfg_pkg::table_op_e o,
                    input logic [1:0] s, input logic sup);
    @(posedge clk_i);
    #1 op_o = {1'b1, o, s, sup};
    @(posedge clk_i);
    #1 op_o = {1'b0, ~op_o[5:0]};
  endtask : op
  task automatic mv(input logic w, input logic [1:0] sel, input logic [1:0] s,
                    input logic sup, input logic [63:0] d);
    @(posedge clk_i);
    #1 mv_o = {1'b1, w, sel, s, sup, d};
    @(posedge clk_i);
    #1 mv_o = {1'b0, ~mv_o[69:0]};
  endtask : mv
endmodule : pipe_model

// ---- table_cfg_pkg.sv ----
/*
  Shared constants and carriers for the table-set configuration and
  permission block. Assumes a 64-bit control-register move path.
*/
package table_cfg_pkg;

  localparam int NUM_SETS  = 4;
  localparam int REG_W     = 64;

  // Configuration register fields
  localparam int CFG_SIGN_BIT  = 6;
  localparam int CFG_ELEMENT_SIZE_FIELD_LSB = 3;
  localparam int CFG_TABLE_COUNT_FIELD_LSB  = 0;
  localparam int CFG_INTERP_LSB = 8;
  localparam int CFG_WSIZE_LSB = 11;
  localparam int CFG_PROMOTION_FIELD_LSB = 24;
  localparam logic [63:0] CFG_RESET = 64'h0000000000000000;
  // Bits software may hold: 28,25-24,23-16,13-7,6-0 (reserved read 0)
  localparam logic [63:0] CFG_KEEP_MASK = 64'h0000000013FF3FFF;

  // Permission register fields
  localparam int PERM_STRIDE = 4;
  localparam logic [63:0] PERM_RESET = 64'h0000000000000000;
  localparam logic [63:0] PERM_MASK  = 64'h0000000000003333;

  localparam logic [1:0] PERM_FULL  = 2'h3;
  localparam logic [1:0] PERM_EXEC  = 2'h2;
  localparam logic [1:0] PERM_READ  = 2'h1;
  localparam logic [1:0] PERM_NONE  = 2'h0;

  // Control register selectors for the move instruction
  localparam logic [1:0] SEL_CONFIG = 2'h0;
  localparam logic [1:0] SEL_BASE   = 2'h1;
  localparam logic [1:0] SEL_PERM   = 2'h2;

  typedef enum logic [2:0] {
    OP_NONE  = 3'b000,
    OP_READ  = 3'b001,
    OP_WRITE = 3'b010,
    OP_INIT  = 3'b011,
    OP_HISTOGRAM_OP  = 3'b100,
    OP_WEIGHTED_HISTOGRAM_OP = 3'b101
  } table_op_e;

  typedef struct packed {
    logic       valid;
    table_op_e  op;
    logic [1:0] set;
    logic       supervisor;
  } table_req_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  sel;
    logic [1:0]  set;
    logic        supervisor;
    logic [63:0] wdata;
  } reg_move_s;

  typedef struct packed {
    logic       is_signed;
    logic [1:0] element_size_field;
    logic [4:0] tables;
    logic [3:0] returned;
    logic [3:0] written;
    logic [3:0] promotion_field_factor;
    logic       cfg_valid;
  } table_decode_s;

endpackage : table_cfg_pkg

// ---- table_cfg_store.sv ----
/*
  Storage for the four per-set configuration words, read data registered.
  Assumes one write and one read port on the core clock.
*/
module table_cfg_store (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        we_i,
  input  wire logic [1:0]  waddr_i,
  input  wire logic [63:0] wdata_i,
  input  wire logic [1:0]  raddr_i,
  output logic      [63:0] rdata_o,
  output logic      [255:0] all_o
);

  logic [63:0] mem_reg [table_cfg_pkg::NUM_SETS];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < table_cfg_pkg::NUM_SETS; i++) begin
        mem_reg[i] <= table_cfg_pkg::CFG_RESET;
      end
    end else if (we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= table_cfg_pkg::CFG_RESET;
    end else begin
      rdata_o <= mem_reg[raddr_i];
    end
  end

  always_comb begin
    for (int i = 0; i < table_cfg_pkg::NUM_SETS; i++) begin
      all_o[i*64 +: 64] = mem_reg[i];
    end
  end

endmodule : table_cfg_store

// ---- table_set_guard.sv ----
/*
  Table-set configuration decode and user-mode permission checking.
  Assumes the pipeline presents one table op and one register move per
  cycle on the core clock; answers come back on the next edge.
*/
// Contract
// - Sign bit six selects signed elements
// - Element size field decodes byte, half, word
// - Table count field decodes 1 to 16
// - User mode faults on unpermitted operations
// - Supervisor mode bypasses all permission checks
// - Permission writes only accepted in supervisor
// - Four two-bit permission fields, rest zero
// - Code 11 allows everything for the set
// - Code 10 allows reads and ops, no writes; code allows table OP_WRITE and refuses only register writes
// - Code 01 allows register and table reads
// - Code 00 allows nothing in user mode; code still accepts user-mode reads of the permission register
// - Interpolation zero writes only indexed element
// - Memory returns maximum; write interpolated count
// - Maximum returned elements follow table count
// - Only listed read combinations are supported
// - Interpolation field decodes 1,2,4,8 elements
// - Promotion field decodes 1x,2x,4x,8x widening
module table_set_guard (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire table_cfg_pkg::table_req_s   op_req_i,
  input  wire table_cfg_pkg::reg_move_s    move_i,
  output logic                             op_allow_o,
  output logic                             op_fault_o,
  output logic                             move_done_o,
  output logic                             move_fault_o,
  output logic                      [63:0] move_rdata_o,
  output logic                             base_we_o,
  output logic                       [1:0] base_set_o,
  output table_cfg_pkg::table_decode_s     decode_o
);

  logic [63:0]  perm_reg;
  logic [63:0]  cfg_rdata;
  logic [255:0] cfg_all;
  logic         cfg_we;
  logic         op_allow_next;
  logic         op_fault_next;
  logic         move_ok;
  logic         move_fault_next;
  logic [1:0]   rd_sel_reg;
  logic         rd_pend_reg;
  logic         rd_fault_reg;
  logic [63:0]  cfg_word;
  table_cfg_pkg::table_decode_s decode_next;

  // Permission code of one set
  function automatic logic [1:0] perm_of(input logic [63:0] p,
                                         input logic [1:0]  s);
    logic [5:0] lsb;
    lsb = 6'(int'(s) * table_cfg_pkg::PERM_STRIDE);
    perm_of = p[lsb +: 2];
  endfunction : perm_of

  // Tables encoded as a power-of-two exponent, 0..4
  function automatic logic [4:0] tables_of(input logic [2:0] code);
    unique case (code)
      3'h0: tables_of = 5'h01;
      3'h1: tables_of = 5'h02;
      3'h2: tables_of = 5'h04;
      3'h3: tables_of = 5'h08;
      3'h4: tables_of = 5'h10;
      default: tables_of = 5'h00;
    endcase
  endfunction : tables_of

  function automatic logic [3:0] pow2(input logic [1:0] e);
    pow2 = 4'(1 << e);
  endfunction : pow2

  // Permission decision for one table operation in user mode
  function automatic logic op_permitted(input logic [1:0] code,
                                        input table_cfg_pkg::table_op_e op);
    unique case (code)
      table_cfg_pkg::PERM_FULL: op_permitted = 1'b1;
      table_cfg_pkg::PERM_EXEC: op_permitted = 1'b1;
      table_cfg_pkg::PERM_READ:
        op_permitted = (op == table_cfg_pkg::OP_READ);
      table_cfg_pkg::PERM_NONE: op_permitted = 1'b0;
    endcase
  endfunction : op_permitted

  // Table operation check
  always_comb begin
    op_allow_next = 1'b0;
    op_fault_next = 1'b0;
    if (op_req_i.valid && op_req_i.op != table_cfg_pkg::OP_NONE) begin
      if (op_req_i.supervisor) begin
        op_allow_next = 1'b1;
      end else if (op_permitted(perm_of(perm_reg, op_req_i.set),
                                op_req_i.op)) begin
        op_allow_next = 1'b1;
      end else begin
        op_fault_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      op_allow_o <= 1'b0;
      op_fault_o <= 1'b0;
    end else begin
      op_allow_o <= op_allow_next;
      op_fault_o <= op_fault_next;
    end
  end

  // Register move check
  always_comb begin
    logic [1:0] code;
    code = perm_of(perm_reg, move_i.set);
    move_ok = 1'b0;
    if (move_i.supervisor) begin
      move_ok = 1'b1;
    end else if (move_i.sel == table_cfg_pkg::SEL_PERM) begin
      move_ok = !move_i.write;
    end else if (move_i.write) begin
      move_ok = (code == table_cfg_pkg::PERM_FULL);
    end else begin
      move_ok = (code != table_cfg_pkg::PERM_NONE);
    end
    move_fault_next = move_i.valid && !move_ok;
  end

  assign cfg_we = move_i.valid && move_ok && move_i.write &&
                  move_i.sel == table_cfg_pkg::SEL_CONFIG;
  assign base_we_o  = move_i.valid && move_ok && move_i.write &&
                      move_i.sel == table_cfg_pkg::SEL_BASE;
  assign base_set_o = move_i.set;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      perm_reg <= table_cfg_pkg::PERM_RESET;
    end else if (move_i.valid && move_ok && move_i.write &&
                 move_i.sel == table_cfg_pkg::SEL_PERM) begin
      perm_reg <= move_i.wdata & table_cfg_pkg::PERM_MASK;
    end
  end

  // Reserved codes of enumerated fields are stored as zero
  always_comb begin
    cfg_word = move_i.wdata & table_cfg_pkg::CFG_KEEP_MASK;
    if (cfg_word[table_cfg_pkg::CFG_ELEMENT_SIZE_FIELD_LSB +: 3] > 3'h2) begin
      cfg_word[table_cfg_pkg::CFG_ELEMENT_SIZE_FIELD_LSB +: 3] = 3'h0;
    end
    if (cfg_word[table_cfg_pkg::CFG_TABLE_COUNT_FIELD_LSB +: 3] > 3'h4) begin
      cfg_word[table_cfg_pkg::CFG_TABLE_COUNT_FIELD_LSB +: 3] = 3'h0;
    end
    if (cfg_word[table_cfg_pkg::CFG_INTERP_LSB +: 3] > 3'h3) begin
      cfg_word[table_cfg_pkg::CFG_INTERP_LSB +: 3] = 3'h0;
    end
    // Weight size keeps byte and half word only
    if (cfg_word[table_cfg_pkg::CFG_WSIZE_LSB +: 3] > 3'h1) begin
      cfg_word[table_cfg_pkg::CFG_WSIZE_LSB +: 3] = 3'h0;
    end
  end

  table_cfg_store u_store (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .we_i    (cfg_we),
    .waddr_i (move_i.set),
    .wdata_i (cfg_word),
    .raddr_i (move_i.set),
    .rdata_o (cfg_rdata),
    .all_o   (cfg_all)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_pend_reg  <= 1'b0;
      rd_fault_reg <= 1'b0;
      rd_sel_reg   <= table_cfg_pkg::SEL_CONFIG;
    end else begin
      rd_pend_reg  <= move_i.valid;
      rd_fault_reg <= move_fault_next;
      rd_sel_reg   <= move_i.sel;
    end
  end

  assign move_done_o  = rd_pend_reg;
  assign move_fault_o = rd_fault_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      move_rdata_o <= 64'h0000000000000000;
    end else if (move_i.valid && !move_i.write && move_ok) begin
      move_rdata_o <= (move_i.sel == table_cfg_pkg::SEL_PERM) ?
                      perm_reg : 64'h0000000000000000;
    end
  end

  // Store read data is left unused; config reads return zero on move_rdata_o
  logic [63:0] unused_cfg_rdata;
  assign unused_cfg_rdata = cfg_rdata;

  // Decode of the configuration of the set addressed by the table op
  always_comb begin
    logic [63:0] c;
    logic [2:0]  table_count_field;
    logic [1:0]  interp;
    logic [1:0]  promotion_field;
    logic [3:0]  maxret;
    logic [15:0] bits;
    logic [8:0]  out_w;
    maxret = 4'h1;
    bits   = 16'h0000;
    out_w  = 9'h000;
    c      = cfg_all[int'(op_req_i.set)*64 +: 64];
    table_count_field   = c[table_cfg_pkg::CFG_TABLE_COUNT_FIELD_LSB +: 3];
    interp = c[table_cfg_pkg::CFG_INTERP_LSB +: 2];
    promotion_field  = c[table_cfg_pkg::CFG_PROMOTION_FIELD_LSB +: 2];
    decode_next.is_signed = c[table_cfg_pkg::CFG_SIGN_BIT];
    decode_next.element_size_field  = c[table_cfg_pkg::CFG_ELEMENT_SIZE_FIELD_LSB +: 2];
    decode_next.tables = tables_of(table_count_field);
    unique case (table_count_field)
      3'h0, 3'h1: maxret = 4'h8;
      3'h2:       maxret = 4'h4;
      3'h3:       maxret = 4'h2;
      default:    maxret = 4'h1;
    endcase
    decode_next.returned = maxret;
    decode_next.written  = pow2(interp);
    decode_next.promotion_field_factor = pow2(promotion_field);
    // Widths sized for the widest promotion: 256-bit elements, 16 tables
    out_w = 9'((8 << decode_next.element_size_field) * int'(pow2(promotion_field)));
    bits  = 16'(int'(out_w) * int'(decode_next.written) *
                int'(decode_next.tables));
    // Output wider than a double word is not representable
    decode_next.cfg_valid = (decode_next.written <= maxret) &&
                            (bits <= 16'h0200) &&
                            (out_w <= 9'h040) &&
                            (bits == 16'h0200 || table_count_field == 3'h0 ||
                             out_w >= 9'h020);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      decode_o <= '0;
    end else begin
      decode_o <= decode_next;
    end
  end

endmodule : table_set_guard

// ---- table_set_guard_monitor.sv ----
/*
  Port checker for the table-set guard.
  Assumes it is bound to every instance of table_set_guard.
*/
module table_set_guard_monitor (
  input wire logic                      clk_i,
  input wire logic                      rst_i,
  input wire table_cfg_pkg::table_req_s op_req_i,
  input wire table_cfg_pkg::reg_move_s  move_i,
  input wire logic                      op_allow_o,
  input wire logic                      op_fault_o,
  input wire logic                      move_done_o,
  input wire logic                      move_fault_o,
  input wire logic               [63:0] move_rdata_o,
  input wire logic                      base_we_o,
  input wire logic                [1:0] base_set_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic op_v;
  assign op_v = op_req_i.valid && (op_req_i.op != table_cfg_pkg::OP_NONE);

  property p_sup_op; op_v && op_req_i.supervisor |=> op_allow_o; endproperty
  a_sup_op: assert property (p_sup_op) else $error("sup op refused");
  property p_one; op_v |=> op_allow_o ^ op_fault_o; endproperty
  a_one: assert property (p_one) else $error("op answer bad");
  property p_idle; !op_v |=> !op_allow_o && !op_fault_o; endproperty
  a_idle: assert property (p_idle) else $error("spurious answer");
  property p_done; move_i.valid |=> move_done_o; endproperty
  a_done: assert property (p_done) else $error("move not done");
  property p_uperm;
    move_i.valid && move_i.write && !move_i.supervisor &&
    move_i.sel == table_cfg_pkg::SEL_PERM |=> move_fault_o;
  endproperty
  a_uperm: assert property (p_uperm) else $error("user perm write ok");
  property p_smove; move_i.valid && move_i.supervisor |=> !move_fault_o;
  endproperty
  a_smove: assert property (p_smove) else $error("sup move fault");
  property p_rsv;
    move_done_o |-> (move_rdata_o & ~table_cfg_pkg::PERM_MASK) == 64'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_bwe;
    base_we_o |-> move_i.valid && move_i.write &&
      move_i.sel == table_cfg_pkg::SEL_BASE;
  endproperty
  a_bwe: assert property (p_bwe) else $error("stray base write");
  property p_hold; move_fault_o |-> $stable(move_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("fault moved data");
  property p_bset; move_i.valid |-> base_set_o == move_i.set; endproperty
  a_bset: assert property (p_bset) else $error("base set wrong");
  property p_sbwe;
    move_i.valid && move_i.write && move_i.supervisor &&
    move_i.sel == table_cfg_pkg::SEL_BASE |-> base_we_o;
  endproperty
  a_sbwe: assert property (p_sbwe) else $error("base write lost");
endmodule : table_set_guard_monitor

bind table_set_guard table_set_guard_monitor u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .op_req_i(op_req_i), .move_i(move_i),
  .op_allow_o(op_allow_o), .op_fault_o(op_fault_o),
  .move_done_o(move_done_o), .move_fault_o(move_fault_o),
  .move_rdata_o(move_rdata_o), .base_we_o(base_we_o),
  .base_set_o(base_set_o));
